// ### czc_device.sv
// Purpose: sensor end, zero point setting, auto-zero and compensation
// Assumes: raw levels arrive on hclk; a store outside keeps the nv image
// Notes:   one command at a time, answered the cycle after it is taken
//
// Functional notes
// - latest zeroing fully replaces earlier zero; here fine adjust shifts the existing zero instead
// - host sets filter 32 before zeroing; here the host only flags a set filter of 32 in ST_FILT
// - known gas zeros to host scaled value
// - nitrogen zero assumes 0 ppm
// - fresh-air reference programmable zero to full scale
// - fresh-air zero uses reference, default 400
// - fine adjust shifts zero by reported error
// - auto-zero off at reset, enable or force
// - auto-zero works like fresh-air zeroing
// - auto-zero reference separate from fresh-air reference
// - start-up delay then independent repeating period
// - power cycle restarts auto-zero timing
// - auto-zero adopts level unless reconfigured
// - compensation replaces default, corrects, persists
// - host derives compensation from pressure difference
// - sleep mode rejects measuring and zeroing commands
// - host terminates commands, spaces before parameters
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module czc_device #(
  parameter int TICK_CYCLES = czc_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // command link
  czc_link_if.dev          link,
  // measurement front end
  input  wire logic        meas_valid,
  input  wire logic [15:0] meas_raw,
  output logic             corr_valid,
  output logic [15:0]      corr_level,
  // nonvolatile store
  input  wire logic        nv_load,
  input  wire logic [15:0] nv_zero,
  input  wire logic [15:0] nv_air_ref,
  input  wire logic [15:0] nv_az_ref,
  input  wire logic [15:0] nv_comp,
  output logic             nv_save,
  output logic [15:0]      zero_point,
  output logic [15:0]      air_ref,
  output logic [15:0]      az_ref,
  output logic [15:0]      comp,
  // auto-zero and mode status
  output logic             az_event,
  output logic [15:0]      az_level,
  output logic [1:0]       op_mode
);

  typedef struct packed {
    logic [15:0] zero;
    logic [15:0] air_ref;
    logic [15:0] az_ref;
    logic [15:0] comp;
    logic [15:0] filter;
    logic [15:0] az_init;
    logic [15:0] az_period;
    logic [15:0] az_min;
    logic [15:0] last_raw;
    logic [1:0]  mode;
    logic        az_en;
    logic        az_adopt;
    logic        az_restart;
    logic        have_raw;
    logic        rsp_valid;
    logic        rsp_err;
    logic [15:0] rsp_data;
    logic        corr_valid;
    logic [15:0] corr;
    logic        nv_save;
    logic        az_event;
    logic [15:0] az_level;
  } czc_dev_s;

  localparam czc_dev_s RST = '{
    zero:      czc_pkg::ZERO_RST,
    air_ref:   czc_pkg::AIR_REF_RST,
    az_ref:    czc_pkg::AZ_REF_RST,
    comp:      czc_pkg::COMP_RST,
    filter:    czc_pkg::FILTER_RST,
    az_init:   czc_pkg::AZ_INIT_RST,
    az_period: czc_pkg::AZ_PERIOD_RST,
    az_min:    16'hffff,
    mode:      czc_pkg::MODE_STREAM,
    az_adopt:  1'b1,
    default:   '0
  };

  czc_dev_s s;
  czc_dev_s next_s;
  logic     az_fire;
  logic     locked;

  // zero offset removed, then scaled by comp / 8192, saturating
  function automatic logic [15:0] correct(input logic [15:0] raw,
                                          input logic [15:0] zero,
                                          input logic [15:0] gain);
    logic [16:0] d;
    logic [31:0] p;
    d = {1'b0, raw} - {1'b0, zero};
    if (d[16]) begin
      d = 17'h0;  // below zero reads as zero
    end
    p = {16'h0, d[15:0]} * {16'h0, gain};
    if (|p[31:29]) begin
      correct = 16'hffff;
    end else begin
      correct = p[28:13];
    end
  endfunction

  czc_az_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .run          (s.az_en),
    .restart      (s.az_restart),
    .init_ticks   (s.az_init),
    .period_ticks (s.az_period),
    .fire         (az_fire)
  );

  // measuring and zeroing are shut off in sleep
  assign locked = (s.mode == czc_pkg::MODE_SLEEP);

  // later stages override earlier ones, so a command wins the cycle
  always_comb begin
    next_s = s;
    next_s.rsp_valid  = 1'b0;
    next_s.corr_valid = 1'b0;
    next_s.nv_save    = 1'b0;
    next_s.az_event   = 1'b0;
    next_s.az_restart = 1'b0;
    // nv image restored by the store after power-up
    if (nv_load) begin
      next_s.zero    = nv_zero;
      next_s.air_ref = nv_air_ref;
      next_s.az_ref  = nv_az_ref;
      next_s.comp    = nv_comp;
    end
    // no measurements while asleep
    if (meas_valid && !locked) begin
      next_s.last_raw   = meas_raw;
      next_s.have_raw   = 1'b1;
      next_s.corr_valid = 1'b1;
      next_s.corr       = correct(meas_raw, s.zero, s.comp);
      // background is the lowest level seen in the period
      if (meas_raw < next_s.az_min) begin
        next_s.az_min = meas_raw;
      end
    end
    // periodic auto-zero, same arithmetic as fresh-air zeroing
    if (az_fire) begin
      next_s.az_event = 1'b1;
      next_s.az_level = s.az_min;
      next_s.az_min   = 16'hffff;
      if (s.az_adopt && !locked && s.az_min != 16'hffff) begin
        next_s.zero    = s.az_min - s.az_ref;
        next_s.nv_save = 1'b1;
      end
    end
    // one command per answer; ready drops while an answer stands
    if (link.cmd_valid && !s.rsp_valid) begin
      next_s.rsp_valid = 1'b1;
      next_s.rsp_err   = 1'b0;
      next_s.rsp_data  = 16'h0;
      case (link.cmd_op)
        czc_pkg::CMD_ZERO_GAS, czc_pkg::CMD_ZERO_N2,
        czc_pkg::CMD_ZERO_AIR, czc_pkg::CMD_ZERO_FINE: begin
          if (locked || !s.have_raw) begin
            next_s.rsp_err = 1'b1;
          end else begin
            // gas, nitrogen and fresh-air overwrite the zero outright; fine adjust shifts it
            case (link.cmd_op)
              czc_pkg::CMD_ZERO_GAS:  next_s.zero = s.last_raw - link.cmd_arg0;
              czc_pkg::CMD_ZERO_N2:   next_s.zero = s.last_raw;
              czc_pkg::CMD_ZERO_AIR:  next_s.zero = s.last_raw - s.air_ref;
              default:                next_s.zero = s.zero + link.cmd_arg1 - link.cmd_arg0;
            endcase
            next_s.nv_save  = 1'b1;
            next_s.rsp_data = next_s.zero;
          end
        end
        czc_pkg::CMD_AZ_CTRL: begin
          if (link.cmd_arg0 == czc_pkg::AZ_FORCE) begin
            if (locked || !s.have_raw) begin
              next_s.rsp_err = 1'b1;
            end else begin
              // forced run uses the latest level, no period wait
              next_s.zero     = s.last_raw - s.az_ref;
              next_s.nv_save  = 1'b1;
              next_s.az_event = 1'b1;
              next_s.az_level = s.last_raw;
              next_s.rsp_data = next_s.zero;
            end
          end else begin
            next_s.az_en      = (link.cmd_arg0 == czc_pkg::AZ_ON);
            next_s.az_restart = 1'b1;
            next_s.rsp_data   = {15'h0, next_s.az_en};
          end
        end
        czc_pkg::CMD_SET_AIR_REF: begin
          next_s.air_ref  = link.cmd_arg0;
          next_s.nv_save  = 1'b1;
          next_s.rsp_data = link.cmd_arg0;
        end
        czc_pkg::CMD_SET_AZ_REF: begin
          next_s.az_ref   = link.cmd_arg0;
          next_s.nv_save  = 1'b1;
          next_s.rsp_data = link.cmd_arg0;
        end
        czc_pkg::CMD_SET_AZ_INIT: begin
          next_s.az_init    = link.cmd_arg0;
          next_s.az_restart = 1'b1;
          next_s.rsp_data   = link.cmd_arg0;
        end
        czc_pkg::CMD_SET_AZ_PERIOD: begin
          next_s.az_period  = link.cmd_arg0;
          next_s.az_restart = 1'b1;
          next_s.rsp_data   = link.cmd_arg0;
        end
        czc_pkg::CMD_SET_AZ_MODE: begin
          next_s.az_adopt = link.cmd_arg0[0];
          next_s.rsp_data = {15'h0, link.cmd_arg0[0]};
        end
        czc_pkg::CMD_SET_COMP: begin
          next_s.comp     = link.cmd_arg0;
          next_s.nv_save  = 1'b1;
          next_s.rsp_data = link.cmd_arg0;
        end
        czc_pkg::CMD_GET_COMP: begin
          next_s.rsp_data = s.comp;
        end
        czc_pkg::CMD_SET_MODE: begin
          if (link.cmd_arg0 > {14'h0, czc_pkg::MODE_POLL}) begin
            next_s.rsp_err = 1'b1;
          end else begin
            next_s.mode     = link.cmd_arg0[1:0];
            next_s.rsp_data = link.cmd_arg0;
          end
        end
        czc_pkg::CMD_READ: begin
          if (locked) begin
            next_s.rsp_err = 1'b1;
          end else begin
            next_s.rsp_data = s.corr;
          end
        end
        czc_pkg::CMD_SET_FILTER: begin
          next_s.filter   = link.cmd_arg0;
          next_s.rsp_data = link.cmd_arg0;
        end
        czc_pkg::CMD_GET_FILTER: begin
          next_s.rsp_data = s.filter;
        end
        default: begin
          next_s.rsp_err = 1'b1;
        end
      endcase
    end
  end

  // all state on one register; nv values are reloaded by the store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= RST;
    end else begin
      s <= next_s;
    end
  end

  // link answers
  assign link.cmd_ready = !s.rsp_valid;
  assign link.rsp_valid = s.rsp_valid;
  assign link.rsp_err   = s.rsp_err;
  assign link.rsp_data  = s.rsp_data;

  // user side
  assign corr_valid = s.corr_valid;
  assign corr_level = s.corr;
  assign nv_save    = s.nv_save;
  assign zero_point = s.zero;
  assign air_ref    = s.air_ref;
  assign az_ref     = s.az_ref;
  assign comp       = s.comp;
  assign az_event   = s.az_event;
  assign az_level   = s.az_level;
  assign op_mode    = s.mode;

endmodule

// ### czc_pkg.sv
// Purpose: shared constants and types for co2 zero calibration and compensation
// Assumes: 200 MHz hclk, 16-bit concentration words
// Notes:   link codes, reset values, host register map and timing counts
package czc_pkg;

  // link command set
  typedef enum logic [3:0] {
    CMD_ZERO_GAS, CMD_ZERO_N2, CMD_ZERO_AIR, CMD_ZERO_FINE,
    CMD_AZ_CTRL, CMD_SET_AIR_REF, CMD_SET_AZ_REF, CMD_SET_AZ_INIT,
    CMD_SET_AZ_PERIOD, CMD_SET_AZ_MODE, CMD_SET_COMP, CMD_GET_COMP,
    CMD_SET_MODE, CMD_READ, CMD_SET_FILTER, CMD_GET_FILTER
  } czc_cmd_e;

  // operating modes, as the mode argument carries them
  localparam logic [1:0] MODE_SLEEP  = 2'h0;
  localparam logic [1:0] MODE_STREAM = 2'h1;
  localparam logic [1:0] MODE_POLL   = 2'h2;

  // auto-zero control argument
  localparam logic [15:0] AZ_OFF   = 16'h0000;
  localparam logic [15:0] AZ_ON    = 16'h0001;
  localparam logic [15:0] AZ_FORCE = 16'h0002;

  // reset values
  localparam logic [15:0] ZERO_RST      = 16'h0000;
  localparam logic [15:0] AIR_REF_RST   = 16'h0190;  // 400 ppm
  localparam logic [15:0] AZ_REF_RST    = 16'h0190;  // 400 ppm
  localparam logic [15:0] COMP_RST      = 16'h2000;  // 8192, unity gain
  localparam int          COMP_SHIFT    = 13;        // 8192 is 2^13
  localparam logic [15:0] FILTER_RST    = 16'h0010;
  localparam logic [15:0] FILTER_ZERO   = 16'h0020;  // 32 for best zero
  localparam logic [15:0] AZ_INIT_RST   = 16'h0001;
  localparam logic [15:0] AZ_PERIOD_RST = 16'h0008;

  // pressure compensation step: 0.14 % of 8192 per mbar, in q10
  localparam logic [31:0] COMP_STEP_Q10 = 32'h00002de0;  // 11744
  localparam int          COMP_Q        = 10;

  // timing: one auto-zero tick
  localparam int CLK_NS          = 5;
  localparam int TICK_NS         = 1000000;            // 1 ms
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_NS;

  // host register map, byte addresses
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ARG    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESP   = 8'h0c;

  // field positions
  localparam int CMD_PRESS_BIT = 8;  // derive comp from sea-level difference
  localparam int ST_BUSY       = 0;
  localparam int ST_DONE       = 1;
  localparam int ST_ERR        = 2;
  localparam int ST_FILT       = 3;
  localparam int ARG1_LSB      = 16;

endpackage

// ### czc_link_if.sv
// Purpose: command and answer link between host end and sensor end
// Assumes: both ends on hclk
// Notes:   one command outstanding; answer is a one-cycle pulse
`timescale 1ns/1ps
interface czc_link_if;
  logic                  cmd_valid;
  logic                  cmd_ready;
  czc_pkg::czc_cmd_e     cmd_op;
  logic [15:0]           cmd_arg0;
  logic [15:0]           cmd_arg1;
  logic                  rsp_valid;
  logic                  rsp_err;
  logic [15:0]           rsp_data;

  modport dev  (input  cmd_valid, cmd_op, cmd_arg0, cmd_arg1,
                output cmd_ready, rsp_valid, rsp_err, rsp_data);
  modport host (output cmd_valid, cmd_op, cmd_arg0, cmd_arg1,
                input  cmd_ready, rsp_valid, rsp_err, rsp_data);
endinterface

// ### czc_az_timer.sv
// Purpose: auto-zero interval timer, start-up delay then repeating period
// Assumes: intervals in ticks of TICK_CYCLES clocks
// Notes:   counts from scratch after every reset
`timescale 1ns/1ps
module czc_az_timer #(
  parameter int TICK_CYCLES = czc_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // control
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic [15:0] init_ticks,
  input  wire logic [15:0] period_ticks,
  // event
  output logic             fire
);

  typedef struct packed {
    logic [31:0] pre;
    logic [15:0] cnt;
    logic        started;
    logic        fire;
  } czc_tmr_s;

  czc_tmr_s s;
  czc_tmr_s next_s;
  logic [15:0] limit;

  // first interval is the start-up delay, later ones the period
  always_comb begin
    next_s = s;
    next_s.fire = 1'b0;
    limit = s.started ? period_ticks : init_ticks;
    if (!run || restart) begin
      next_s.pre = 32'h0;
      next_s.cnt = 16'h0;
    end else if (s.pre == 32'(TICK_CYCLES - 1)) begin
      next_s.pre = 32'h0;
      // a zero interval acts as one tick
      if (s.cnt + 16'h1 >= limit) begin
        next_s.cnt     = 16'h0;
        next_s.fire    = 1'b1;
        next_s.started = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 16'h1;
      end
    end else begin
      next_s.pre = s.pre + 32'h1;
    end
  end

  // reset returns to the start-up delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fire = s.fire;

endmodule

// ### czc_host.sv
// Purpose: host end, AHB-Lite register slave that drives the command link
// Assumes: zero wait states, single word transfers only
// Notes:   read data is captured in the address phase
`timescale 1ns/1ps
module czc_host #(
  parameter logic [15:0] RANGE_MULT = 16'h0001
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // command link
  czc_link_if.host         link
);

  typedef struct packed {
    logic              wr_pend;
    logic [7:0]        wr_addr;
    logic [31:0]       rdata;
    logic [15:0]       arg0;
    logic [15:0]       arg1;
    czc_pkg::czc_cmd_e op;
    logic              press;
    logic              busy;
    logic              done;
    logic              err;
    logic [15:0]       resp;
    logic              filt_ok;
    logic              cmd_valid;
    logic [15:0]       out_arg0;
    logic [15:0]       out_arg1;
  } czc_host_s;

  czc_host_s   s;
  czc_host_s   next_s;
  logic        take;
  logic        clr_done;
  logic        start;
  czc_pkg::czc_cmd_e wop;
  logic [31:0] comp_p;

  assign take = hsel && hready && htrans[1];
  assign wop  = czc_pkg::czc_cmd_e'(hwdata[3:0]);

  // bus side, then link side; hardware set of done beats the clear
  always_comb begin
    next_s   = s;
    clr_done = 1'b0;
    start    = 1'b0;
    comp_p   = 32'h0;
    if (take) begin
      next_s.wr_pend = hwrite;
      next_s.wr_addr = haddr[7:0];
      case (haddr[7:0])
        czc_pkg::REG_CMD:    next_s.rdata = {23'h0, s.press, 4'h0, s.op};
        czc_pkg::REG_ARG:    next_s.rdata = {s.arg1, s.arg0};
        czc_pkg::REG_STATUS: next_s.rdata = {28'h0, s.filt_ok, s.err, s.done, s.busy};
        czc_pkg::REG_RESP:   next_s.rdata = {16'h0, s.resp};
        default:             next_s.rdata = 32'h0;
      endcase
    end else begin
      next_s.wr_pend = 1'b0;
    end
    // write data phase
    if (s.wr_pend) begin
      case (s.wr_addr)
        czc_pkg::REG_ARG: begin
          next_s.arg0 = hwdata[15:0];
          next_s.arg1 = hwdata[31:16];
        end
        czc_pkg::REG_STATUS: clr_done = hwdata[czc_pkg::ST_DONE];
        czc_pkg::REG_CMD:    start = !s.busy;  // ignored while busy
        default: ;
      endcase
    end
    if (start) begin
      next_s.op        = wop;
      next_s.press     = hwdata[czc_pkg::CMD_PRESS_BIT];
      next_s.busy      = 1'b1;
      next_s.cmd_valid = 1'b1;
      next_s.out_arg0  = s.arg0;
      next_s.out_arg1  = s.arg1;
      case (wop)
        // concentrations go out in the sensor's range units
        czc_pkg::CMD_ZERO_GAS, czc_pkg::CMD_SET_AIR_REF,
        czc_pkg::CMD_SET_AZ_REF: begin
          next_s.out_arg0 = 16'(s.arg0 * RANGE_MULT);
        end
        czc_pkg::CMD_ZERO_FINE: begin
          next_s.out_arg0 = 16'(s.arg0 * RANGE_MULT);
          next_s.out_arg1 = 16'(s.arg1 * RANGE_MULT);
        end
        czc_pkg::CMD_SET_COMP: begin
          // arg0 as mbar below sea level: 8192 plus 0.14 % per mbar
          if (hwdata[czc_pkg::CMD_PRESS_BIT]) begin
            comp_p = ({16'h0, s.arg0} * czc_pkg::COMP_STEP_Q10) >> czc_pkg::COMP_Q;
            next_s.out_arg0 = czc_pkg::COMP_RST + comp_p[15:0];
          end
        end
        default: ;
      endcase
    end
    // link handshake
    if (s.cmd_valid && link.cmd_ready) begin
      next_s.cmd_valid = 1'b0;
    end
    next_s.done = s.done && !clr_done;
    if (s.busy && !s.cmd_valid && link.rsp_valid) begin
      next_s.busy = 1'b0;
      next_s.done = 1'b1;
      next_s.err  = link.rsp_err;
      next_s.resp = link.rsp_data;
      // track whether the smoothing filter suits zeroing
      if (s.op == czc_pkg::CMD_SET_FILTER && !link.rsp_err) begin
        next_s.filt_ok = (link.rsp_data == czc_pkg::FILTER_ZERO);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // hsize is always a word here; no wait states, always OKAY
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = s.rdata;
  assign link.cmd_valid = s.cmd_valid;
  assign link.cmd_op    = s.op;
  assign link.cmd_arg0  = s.out_arg0;
  assign link.cmd_arg1  = s.out_arg1;

endmodule

// ### czc_props.sv
// Purpose: link checks between the host end and the sensor end
// Assumes: one hclk domain, one command outstanding
// Notes:   sleep is tracked from accepted mode commands
`timescale 1ns/1ps
module czc_props (
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // link
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire czc_pkg::czc_cmd_e cmd_op,
  input wire logic [15:0]       cmd_arg0,
  input wire logic [15:0]       cmd_arg1,
  input wire logic              rsp_valid,
  input wire logic              rsp_err,
  input wire logic [15:0]       rsp_data
);
  logic take;
  logic sleep;
  assign take = cmd_valid && cmd_ready;
  // mode follows accepted mode commands only, bad codes leave it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep <= 1'b0;
    end else if (take && cmd_op == czc_pkg::CMD_SET_MODE && cmd_arg0 <= 16'h0002) begin
      sleep <= (cmd_arg0 == 16'h0000);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rsp_after_take;
    take |=> rsp_valid;
  endproperty
  property p_rsp_pulse;
    rsp_valid |=> !rsp_valid;
  endproperty
  property p_rsp_caused;
    rsp_valid |-> $past(take);
  endproperty
  property p_ready_low;
    cmd_ready != rsp_valid;
  endproperty
  property p_hold_req;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_op) && $stable(cmd_arg0) && $stable(cmd_arg1);
  endproperty
  property p_valid_drop;
    take |=> !cmd_valid;
  endproperty
  property p_rsp_hold;
    !rsp_valid |-> $stable(rsp_data) && $stable(rsp_err);
  endproperty
  property p_mode_err;
    take && cmd_op == czc_pkg::CMD_SET_MODE && cmd_arg0 > 16'h0002 |=> rsp_valid && rsp_err;
  endproperty
  property p_sleep_reject;
    take && sleep && cmd_op inside {czc_pkg::CMD_ZERO_GAS, czc_pkg::CMD_ZERO_N2, czc_pkg::CMD_ZERO_AIR,
      czc_pkg::CMD_ZERO_FINE, czc_pkg::CMD_READ} |=> rsp_valid && rsp_err;
  endproperty
  a_rsp_after_take: assert property (p_rsp_after_take) else $error("no answer after take");
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer longer than one cycle");
  a_rsp_caused: assert property (p_rsp_caused) else $error("answer without command");
  a_ready_low: assert property (p_ready_low) else $error("ready not inverse of answer");
  a_hold_req: assert property (p_hold_req) else $error("request changed while waiting");
  a_valid_drop: assert property (p_valid_drop) else $error("valid held after take");
  a_rsp_hold: assert property (p_rsp_hold) else $error("answer word changed");
  a_mode_err: assert property (p_mode_err) else $error("bad mode accepted");
  a_sleep_reject: assert property (p_sleep_reject) else $error("zeroing accepted in sleep");
  // main scenarios reached
  c_sleep_take: cover property (take && sleep);
  c_fine: cover property (take && cmd_op == czc_pkg::CMD_ZERO_FINE);
  c_err: cover property (rsp_valid && rsp_err);
endmodule

// ### co2_zero_calibration_compensation_test.sv
// Purpose: drives both ends, zeroing, auto-zero and compensation checks
// Assumes: host end answers with zero wait states
// Notes:   tick shortened to 4 clocks
`timescale 1ns/1ps
module co2_zero_calibration_compensation_test;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, meas_valid, corr_valid, nv_load, nv_save;
  logic        az_event, az_seen, sv_seen;
  logic [1:0]  htrans, op_mode;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, st, r;
  logic [15:0] meas_raw, corr_level, nv_zero, nv_air_ref, nv_az_ref, nv_comp;
  logic [15:0] zero_point, air_ref, az_ref, comp, az_level;
  int          errors, comparisons, cycles;
  czc_link_if czc_link_if_inst();
  czc_device #(.TICK_CYCLES(4)) czc_device_inst (.hclk(hclk), .hresetn(hresetn), .link(czc_link_if_inst),
    .meas_valid(meas_valid), .meas_raw(meas_raw), .corr_valid(corr_valid), .corr_level(corr_level),
    .nv_load(nv_load), .nv_zero(nv_zero), .nv_air_ref(nv_air_ref), .nv_az_ref(nv_az_ref), .nv_comp(nv_comp),
    .nv_save(nv_save), .zero_point(zero_point), .air_ref(air_ref), .az_ref(az_ref), .comp(comp),
    .az_event(az_event), .az_level(az_level), .op_mode(op_mode));
  czc_host #(.RANGE_MULT(16'h0002)) czc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .link(czc_link_if_inst));
  czc_props czc_props_inst (.hclk(hclk), .hresetn(hresetn), .cmd_valid(czc_link_if_inst.cmd_valid),
    .cmd_ready(czc_link_if_inst.cmd_ready), .cmd_op(czc_link_if_inst.cmd_op),
    .cmd_arg0(czc_link_if_inst.cmd_arg0), .cmd_arg1(czc_link_if_inst.cmd_arg1),
    .rsp_valid(czc_link_if_inst.rsp_valid), .rsp_err(czc_link_if_inst.rsp_err),
    .rsp_data(czc_link_if_inst.rsp_data));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // hang guard, plus pulse monitors
  always @(posedge hclk) begin
    cycles++;
    if (az_event === 1'b1) az_seen = 1'b1;
    if (nv_save === 1'b1) sv_seen = 1'b1;
    if (cycles > 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge; address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk(16'(hresp), 16'h0);
  endtask
  // issue one command, poll for done, check error flag, fetch answer
  task automatic cmd(input logic [31:0] op, input logic [31:0] arg, input logic err);
    logic [31:0] d;
    ahb(1'b1, czc_pkg::REG_ARG, arg, d);
    ahb(1'b1, czc_pkg::REG_CMD, op, d);
    do ahb(1'b0, czc_pkg::REG_STATUS, 32'h0, st);
    while (st[czc_pkg::ST_DONE] !== 1'b1);
    chk(16'(st[czc_pkg::ST_ERR]), 16'(err));
    ahb(1'b0, czc_pkg::REG_RESP, 32'h0, r);
    ahb(1'b1, czc_pkg::REG_STATUS, 32'h2, d);
  endtask
  task automatic meas(input logic [15:0] raw, input logic [15:0] exp);
    meas_valid <= 1'b1;
    meas_raw <= raw;
    @(posedge hclk);
    meas_valid <= 1'b0;
    @(posedge hclk);
    chk(16'(corr_valid), 16'h1);
    chk(corr_level, exp);
  endtask
  task automatic wait_az(input logic [15:0] lvl);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (!(az_event === 1'b1 && az_level === lvl) && n < 300);
    chk(16'(n < 300), 16'h1);
  endtask
  initial begin
    {hsel, hwrite, meas_valid, nv_load, az_seen, sv_seen} = '0;
    {haddr, hwdata, htrans, meas_raw, nv_zero, nv_air_ref, nv_az_ref, nv_comp} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(air_ref, 16'h0190);
    chk(comp, 16'h2000);
    chk(16'(op_mode), 16'h0001);
    meas(16'd1000, 16'd1000);
    cmd(czc_pkg::CMD_ZERO_N2, 32'h0, 1'b0);
    chk(r[15:0], 16'd1000);
    cmd(czc_pkg::CMD_ZERO_GAS, 32'd100, 1'b0);
    chk(zero_point, 16'd800);
    cmd(czc_pkg::CMD_ZERO_AIR, 32'h0, 1'b0);
    chk(zero_point, 16'd600);
    cmd(czc_pkg::CMD_SET_AIR_REF, 32'd50, 1'b0);
    cmd(czc_pkg::CMD_ZERO_AIR, 32'h0, 1'b0);
    chk(zero_point, 16'd900);
    cmd(czc_pkg::CMD_ZERO_FINE, {16'd200, 16'd205}, 1'b0);
    chk(zero_point, 16'd890);
    chk(16'(sv_seen), 16'h1);
    meas(16'd1000, 16'd110);
    cmd(32'h100 | czc_pkg::CMD_SET_COMP, 32'd18, 1'b0);
    chk(comp, 16'd8398);
    meas(16'd1000, 16'd112);
    cmd(czc_pkg::CMD_SET_FILTER, 32'd32, 1'b0);
    cmd(czc_pkg::CMD_GET_FILTER, 32'h0, 1'b0);
    chk(16'(st[czc_pkg::ST_FILT]), 16'h1);
    // auto-zero: off until enabled, own reference, force, then timed
    chk(16'(az_seen), 16'h0);
    cmd(czc_pkg::CMD_SET_AZ_REF, 32'd25, 1'b0);
    chk(air_ref, 16'd100);
    cmd(czc_pkg::CMD_AZ_CTRL, 32'(czc_pkg::AZ_FORCE), 1'b0);
    chk(zero_point, 16'd950);
    meas(16'd700, 16'd0);
    cmd(czc_pkg::CMD_SET_AZ_INIT, 32'd20, 1'b0);
    cmd(czc_pkg::CMD_AZ_CTRL, 32'(czc_pkg::AZ_ON), 1'b0);
    wait_az(16'd700);
    @(posedge hclk);
    chk(zero_point, 16'd650);
    cmd(czc_pkg::CMD_SET_AZ_MODE, 32'h0, 1'b0);
    meas(16'd600, 16'd0);
    wait_az(16'd600);
    @(posedge hclk);
    chk(zero_point, 16'd650);
    // sleep refuses zeroing, bad mode code refused
    cmd(czc_pkg::CMD_SET_MODE, 32'h0, 1'b0);
    chk(16'(op_mode), 16'h0);
    cmd(czc_pkg::CMD_ZERO_N2, 32'h0, 1'b1);
    chk(zero_point, 16'd650);
    cmd(czc_pkg::CMD_SET_MODE, 32'h3, 1'b1);
    cmd(czc_pkg::CMD_SET_MODE, 32'h1, 1'b0);
    // restore from the outside store
    nv_load <= 1'b1;
    {nv_zero, nv_air_ref, nv_az_ref, nv_comp} <= {16'h0040, 16'h0111, 16'h0222, 16'h3000};
    @(posedge hclk);
    nv_load <= 1'b0;
    @(posedge hclk);
    chk(az_ref, 16'h0222);
    meas(16'd1000, 16'd1404);
    end_sim();
  end
endmodule
